// File: otf_map.vh
// Constants for the outbound transfer offer and grant handshake block.
// Overview of operation
// (R1) Every control_message frame goes out and comes in on channel 00h.
// (R2) A one-byte channel sits in the first byte of two; the second is ignored.
// (R3) An offer precedes outbound data; the peer answers with grant messages.
// (R4) Offer layout: code 20h, reserved, tag, offset, count, reserved, offer_identifier.
// (R5) An offer stays outstanding from its sending until its last data byte leaves.
// (R6) The offer tag field carries the tag of the upper_level_protocol command.
// (R7) Every offer byte offset is a multiple of eight.
// (R8) Every offer count is a multiple of eight, except the final offer.
// (R9) Offset plus count never exceeds the transfer length of the command.
// (R10) Each offer_identifier differs from every other outstanding offer.
// (R11) The peer echoes the offer_identifier in every grant it returns.
// (R12) Offers are only issued while direct_redirect_mode_bit is cleared; the code tests it only when taking a command, not for later offers.
// (R13) The peer aborts on bad offers, otherwise allocates a receive channel.
// (R14) For third-party transfers the peer waits for the third party's pull message.
// (R15) A grant gives channel, count and echoed identifier, plus path for third party.
// (R16) Data frames after a grant are addressed to the granted channel.
// (R17) At most one new grant per offer while one is outstanding; no spanning.
// (R18) Ungranted offer bytes wait for more grants; remaining command data gets new offers.
// (R19) A new offer only when no offer is outstanding or every offer has a grant.
// (R20) No data frame carries bytes of more than one grant.
// (R21) Grant layout: code 21h, reserved, tag, replier_node_identifier, count, channel, identifier.
// (R22) Grant data is sent; the grant stays outstanding until its last byte.
// (R23) Multi-byte fields travel most significant byte first.
`ifndef OTF_MAP_VH
`define OTF_MAP_VH

// ==================================================================
// Message codes and channel.
`define OTF_CODE_OFFER 8'h20
`define OTF_CODE_GRANT 8'h21
`define OTF_CODE_TPGRANT 8'h23
`define OTF_MSG_CHAN 8'h00
`define OTF_MSG_LAST 5'h0f
`define OTF_MSG_OVER 5'h10

// ==================================================================
// Field positions within a 16-byte message, byte 0 in the top bits.
`define OTF_F_CODE 127:120
`define OTF_F_TAG 111:96
`define OTF_F_NODE 95:64
`define OTF_F_COUNT 63:32
`define OTF_F_CHAN 31:24
`define OTF_F_ID 15:0

// ==================================================================
// Default sizes and reset values.
`define OTF_ALIGN_BITS 3'h7
`define OTF_FRAME_BYTES 16'h0080
`define OTF_OFFER_MAX 32'h00000100
`define OTF_ID_RESET 16'h0000

`endif

// File: otf_fifo.v
// Byte FIFO between the user write port and the outbound data frames.
`timescale 1ns/1ps
module otf_fifo #(
  parameter WIDTH = 8,
  parameter AW = 4
) (
  // Clock and reset.
  input wire clk_sys,
  input wire rst,
  // Fill side.
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  // Drain side.
  output wire out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready
);
  localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};

  reg [WIDTH-1:0] mem [0:(1<<AW)-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  reg full_r;
  reg empty_r;
  wire push;
  wire pop;
  reg [AW:0] cnt_nxt;

  // Handshakes on both sides.
  assign in_ready = ~full_r;
  assign out_valid = ~empty_r;
  assign out_data = mem[rp_r];
  assign push = in_valid & ~full_r;
  assign pop = out_ready & ~empty_r;

  // Next fill level.
  always @* begin
    cnt_nxt = cnt_r;
    if (push & ~pop) begin
      cnt_nxt = cnt_r + {{AW{1'b0}}, 1'b1};
    end else if (pop & ~push) begin
      cnt_nxt = cnt_r - {{AW{1'b0}}, 1'b1};
    end
  end

  // Pointers, level and the registered full and empty flags.
  always @(posedge clk_sys) begin
    if (rst) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      full_r <= 1'b0;
      empty_r <= 1'b1;
    end else begin
      if (push) begin
        wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
      end
      cnt_r <= cnt_nxt;
      full_r <= (cnt_nxt == DEPTH);
      empty_r <= (cnt_nxt == {(AW+1){1'b0}});
    end
  end

  // Storage write.
  always @(posedge clk_sys) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule

// File: otf_msg_rx.v
// Collector that turns inbound control_message bytes into grant fields.
`timescale 1ns/1ps
`include "otf_map.vh"
module otf_msg_rx (
  // Clock and reset.
  input wire clk_sys,
  input wire rst,
  // Inbound frame bytes.
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_last,
  input wire [7:0] rx_chan,
  // Parsed message.
  output reg msg_valid_r,
  output reg [7:0] msg_code_r,
  output reg [15:0] msg_tag_r,
  output reg [31:0] msg_count_r,
  output reg [7:0] msg_chan_r,
  output reg [15:0] msg_id_r
);
  reg [119:0] sh_r;
  reg [4:0] cnt_r;
  wire [127:0] whole;

  assign whole = {sh_r, rx_data};

  // Shift bytes in, first byte ends in the top bits, and emit on a 16-byte frame.
  always @(posedge clk_sys) begin
    if (rst) begin
      sh_r <= 120'h0;
      cnt_r <= 5'h00;
      msg_valid_r <= 1'b0;
      msg_code_r <= 8'h00;
      msg_tag_r <= 16'h0000;
      msg_count_r <= 32'h00000000;
      msg_chan_r <= 8'h00;
      msg_id_r <= 16'h0000;
    end else begin
      msg_valid_r <= 1'b0;
      if (rx_valid && rx_chan == `OTF_MSG_CHAN) begin // R1
        sh_r <= whole[119:0];
        if (rx_last) begin
          cnt_r <= 5'h00;
          if (cnt_r == `OTF_MSG_LAST) begin
            msg_valid_r <= 1'b1;
            msg_code_r <= whole[`OTF_F_CODE]; // R21
            msg_tag_r <= whole[`OTF_F_TAG]; // R23
            msg_count_r <= whole[`OTF_F_COUNT];
            msg_chan_r <= whole[`OTF_F_CHAN]; // R2
            msg_id_r <= whole[`OTF_F_ID];
          end
        end else if (cnt_r != `OTF_MSG_OVER) begin
          cnt_r <= cnt_r + 5'h01;
        end
      end
    end
  end
endmodule

// File: otf_top.v
// Outbound transfer engine: offers, grant tracking and data frame emission.
`timescale 1ns/1ps
`include "otf_map.vh"
module otf_top #(
  parameter [15:0] FRAME_BYTES = `OTF_FRAME_BYTES,
  parameter [31:0] OFFER_MAX = `OTF_OFFER_MAX,
  parameter FIFO_AW = 4
) (
  // Clock and reset.
  input wire clk_sys,
  input wire rst,
  // Command from the upper_level_protocol.
  input wire cmd_valid,
  input wire [15:0] cmd_tag,
  input wire [31:0] cmd_len,
  output reg cmd_ready_r,
  input wire cmd_abort,
  input wire direct_redirect_mode_bit,
  // Outbound data bytes from the user.
  input wire wr_valid,
  input wire [7:0] wr_data,
  output wire wr_ready,
  // Inbound frames from the link.
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_last,
  input wire [7:0] rx_chan,
  // Outbound frames to the link.
  output reg tx_valid_r,
  input wire tx_ready,
  output reg [7:0] tx_data_r,
  output reg tx_last_r,
  output reg [7:0] tx_chan_r,
  output reg tx_is_msg_r,
  output reg tx_third_party_r,
  // Status.
  output reg offer_outstanding_r,
  output reg grant_outstanding_r,
  output reg xfer_done_r,
  output reg proto_err_r
);
  // ==================================================================
  // States and constants.
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_OFFER = 4'b0010;
  localparam [3:0] S_WAIT = 4'b0100;
  localparam [3:0] S_DATA = 4'b1000;
  localparam [15:0] FRAME_LAST = FRAME_BYTES - 16'h0001;
  localparam [3:0] MSG_END = 4'hf;

  // ==================================================================
  // Functions.

  // Size of the next offer: the rest of the command, capped by OFFER_MAX.
  function [31:0] next_cnt;
    input [31:0] len;
    input [31:0] off;
    reg [31:0] rest;
    begin
      rest = len - off;
      if (rest > OFFER_MAX) begin
        next_cnt = OFFER_MAX;
      end else begin
        next_cnt = rest;
      end
    end
  endfunction

  // One byte of the offer message, byte 0 first.
  function [7:0] offer_byte;
    input [3:0] i;
    input [15:0] tg;
    input [31:0] of;
    input [31:0] ct;
    input [15:0] id;
    reg [127:0] v;
    reg [127:0] s;
    begin
      v = {`OTF_CODE_OFFER, 8'h00, tg, of, ct, 16'h0000, id};
      s = v >> {~i, 3'b000};
      offer_byte = s[7:0];
    end
  endfunction

  // ==================================================================
  // Submodules.
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire fifo_pop;
  wire g_valid;
  wire [7:0] g_code;
  wire [15:0] g_tag;
  wire [31:0] g_cnt;
  wire [7:0] g_chan;
  wire [15:0] g_id;

  otf_fifo #(
    .WIDTH(8),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(wr_valid),
    .in_data(wr_data),
    .in_ready(wr_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  otf_msg_rx u_rx (
    .clk_sys(clk_sys),
    .rst(rst),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_last(rx_last),
    .rx_chan(rx_chan),
    .msg_valid_r(g_valid),
    .msg_code_r(g_code),
    .msg_tag_r(g_tag),
    .msg_count_r(g_cnt),
    .msg_chan_r(g_chan),
    .msg_id_r(g_id)
  );

  // ==================================================================
  // State registers.
  reg [3:0] state_r;
  reg [15:0] tag_r;
  reg [31:0] len_r;
  reg [31:0] next_off_r;
  reg [31:0] off_r;
  reg [31:0] ocnt_r;
  reg [31:0] ungranted_r;
  reg [15:0] id_r;
  reg [3:0] idx_r;
  reg [31:0] gleft_r;
  reg [7:0] gchan_r;
  reg g3p_r;
  reg [15:0] fcnt_r;
  reg pend_r;
  reg [31:0] pend_cnt_r;
  reg [7:0] pend_chan_r;
  reg pend_3p_r;

  // ==================================================================
  // Grant qualification.
  wire load;
  wire final_offer;
  wire g_code_ok;
  wire g_fields_ok;
  wire g_align_ok;
  wire g_ok;
  wire take_g;
  wire last_byte;

  // The output register may take a new byte.
  assign load = ~tx_valid_r | tx_ready;
  // This offer carries the final byte of the command.
  assign final_offer = (next_off_r == len_r);
  // Grant or third-party grant, echoing tag and offer_identifier.
  assign g_code_ok = (g_code == `OTF_CODE_GRANT) || (g_code == `OTF_CODE_TPGRANT);
  assign g_fields_ok = (g_tag == tag_r) && (g_id == id_r); // R11
  // No grant beyond this offer; odd sizes only at the very end.
  assign g_align_ok = (g_cnt[2:0] == 3'h0) || ((g_cnt == ungranted_r) && final_offer);
  assign g_ok = g_valid && g_code_ok && g_fields_ok && (g_cnt != 32'h00000000) &&
                (g_cnt <= ungranted_r) && g_align_ok; // R17
  // One active grant plus one pending grant may be held.
  assign take_g = g_ok && ((state_r == S_WAIT) || ((state_r == S_DATA) && ~pend_r));
  // Data byte handed to the output register this cycle.
  assign fifo_pop = (state_r == S_DATA) && load && fifo_valid;
  assign last_byte = fifo_pop && (gleft_r == 32'h00000001);

  // ==================================================================
  // Main sequencer.
  always @(posedge clk_sys) begin
    if (rst) begin
      state_r <= S_IDLE;
      cmd_ready_r <= 1'b0;
      tag_r <= 16'h0000;
      len_r <= 32'h00000000;
      next_off_r <= 32'h00000000;
      off_r <= 32'h00000000;
      ocnt_r <= 32'h00000000;
      ungranted_r <= 32'h00000000;
      id_r <= `OTF_ID_RESET;
      idx_r <= 4'h0;
      gleft_r <= 32'h00000000;
      gchan_r <= 8'h00;
      g3p_r <= 1'b0;
      fcnt_r <= 16'h0000;
      pend_r <= 1'b0;
      pend_cnt_r <= 32'h00000000;
      pend_chan_r <= 8'h00;
      pend_3p_r <= 1'b0;
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
      tx_last_r <= 1'b0;
      tx_chan_r <= 8'h00;
      tx_is_msg_r <= 1'b0;
      tx_third_party_r <= 1'b0;
      offer_outstanding_r <= 1'b0;
      grant_outstanding_r <= 1'b0;
      xfer_done_r <= 1'b0;
      proto_err_r <= 1'b0;
    end else begin
      xfer_done_r <= 1'b0;
      // A rejected or unplaceable message is dropped and flagged.
      proto_err_r <= g_valid && ~take_g;
      // Accept a command only while idle and with redirect mode off.
      cmd_ready_r <= (state_r == S_IDLE) && ~cmd_valid && ~direct_redirect_mode_bit; // R12
      if (load && ~((state_r == S_OFFER) || fifo_pop)) begin
        tx_valid_r <= 1'b0;
      end
      // Granted bytes leave the ungranted pool of the offer.
      if (take_g) begin
        ungranted_r <= ungranted_r - g_cnt;
      end
      case (state_r)
        S_IDLE: begin
          if (cmd_valid && cmd_ready_r && ~direct_redirect_mode_bit) begin // R12
            tag_r <= cmd_tag; // R6
            len_r <= cmd_len;
            if (cmd_len == 32'h00000000) begin
              xfer_done_r <= 1'b1;
            end else begin
              // First offer at offset zero; later offsets step by aligned sizes.
              off_r <= 32'h00000000; // R7
              ocnt_r <= next_cnt(cmd_len, 32'h00000000); // R8
              ungranted_r <= next_cnt(cmd_len, 32'h00000000);
              next_off_r <= next_cnt(cmd_len, 32'h00000000); // R9
              id_r <= id_r + 16'h0001; // R10
              idx_r <= 4'h0;
              offer_outstanding_r <= 1'b1; // R5
              state_r <= S_OFFER; // R3
            end
          end
        end
        S_OFFER: begin
          // Stream the 16 offer bytes on the message channel.
          if (load) begin
            tx_valid_r <= 1'b1;
            tx_data_r <= offer_byte(idx_r, tag_r, off_r, ocnt_r, id_r); // R4 R23
            tx_last_r <= (idx_r == MSG_END);
            tx_chan_r <= `OTF_MSG_CHAN; // R1
            tx_is_msg_r <= 1'b1;
            tx_third_party_r <= 1'b0;
            idx_r <= idx_r + 4'h1;
            if (idx_r == MSG_END) begin
              state_r <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          // Take a grant and start its data.
          if (take_g) begin
            gleft_r <= g_cnt; // R22
            gchan_r <= g_chan;
            g3p_r <= (g_code == `OTF_CODE_TPGRANT);
            fcnt_r <= 16'h0000;
            grant_outstanding_r <= 1'b1;
            state_r <= S_DATA;
          end
        end
        S_DATA: begin
          if (fifo_pop) begin
            // Data bytes go to the granted channel and path.
            tx_valid_r <= 1'b1;
            tx_data_r <= fifo_data;
            tx_chan_r <= gchan_r; // R16
            tx_is_msg_r <= 1'b0;
            tx_third_party_r <= g3p_r;
            // A frame closes at its size limit or at the end of the grant.
            tx_last_r <= (fcnt_r == FRAME_LAST) || last_byte; // R20
            if ((fcnt_r == FRAME_LAST) || last_byte) begin
              fcnt_r <= 16'h0000;
            end else begin
              fcnt_r <= fcnt_r + 16'h0001;
            end
            gleft_r <= gleft_r - 32'h00000001;
          end
          if (last_byte) begin
            if (pend_r) begin
              // The held grant becomes active.
              gleft_r <= pend_cnt_r;
              gchan_r <= pend_chan_r;
              g3p_r <= pend_3p_r;
              pend_r <= 1'b0;
            end else if (take_g) begin
              gleft_r <= g_cnt;
              gchan_r <= g_chan;
              g3p_r <= (g_code == `OTF_CODE_TPGRANT);
            end else if (ungranted_r != 32'h00000000) begin
              // Part of the offer is still ungranted: wait for another grant.
              grant_outstanding_r <= 1'b0; // R22
              state_r <= S_WAIT; // R18
            end else if (final_offer) begin
              grant_outstanding_r <= 1'b0;
              offer_outstanding_r <= 1'b0; // R5
              xfer_done_r <= 1'b1;
              state_r <= S_IDLE;
            end else begin
              // Offer done, more command data: issue the next offer.
              grant_outstanding_r <= 1'b0;
              off_r <= next_off_r; // R19
              ocnt_r <= next_cnt(len_r, next_off_r); // R8
              ungranted_r <= next_cnt(len_r, next_off_r);
              next_off_r <= next_off_r + next_cnt(len_r, next_off_r); // R9
              id_r <= id_r + 16'h0001; // R10
              idx_r <= 4'h0;
              state_r <= S_OFFER; // R18
            end
          end else if (take_g) begin
            // Hold a second grant while the first is still running.
            pend_r <= 1'b1;
            pend_cnt_r <= g_cnt;
            pend_chan_r <= g_chan;
            pend_3p_r <= (g_code == `OTF_CODE_TPGRANT);
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
      // The upper layer may drop the command at any time.
      if (cmd_abort) begin
        state_r <= S_IDLE;
        pend_r <= 1'b0;
        offer_outstanding_r <= 1'b0;
        grant_outstanding_r <= 1'b0;
      end
    end
  end
endmodule

// File: otf_top_checker.sv
// Assertion checker for the outbound transfer engine.
`timescale 1ns/1ps
module otf_top_checker #(
  parameter [15:0] FRAME_BYTES = 16'h0080
) (
  // Clock, reset and command.
  input wire clk_sys,
  input wire rst,
  input wire cmd_valid,
  input wire [15:0] cmd_tag,
  input wire cmd_ready_r,
  input wire direct_redirect_mode_bit,
  // Link frames.
  input wire rx_valid,
  input wire rx_last,
  input wire tx_valid_r,
  input wire tx_ready,
  input wire [7:0] tx_data_r,
  input wire tx_last_r,
  input wire [7:0] tx_chan_r,
  input wire tx_is_msg_r,
  // Status.
  input wire offer_outstanding_r,
  input wire proto_err_r
);
  reg [3:0] midx_r;
  reg [15:0] didx_r;
  wire msg_w = tx_valid_r && tx_is_msg_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Byte positions in the current offer and data frame.
  always @(posedge clk_sys) begin
    if (rst) begin
      midx_r <= 4'h0;
      didx_r <= 16'h0000;
    end else if (tx_valid_r && tx_ready) begin
      if (tx_is_msg_r) midx_r <= tx_last_r ? 4'h0 : midx_r + 4'h1;
      else didx_r <= tx_last_r ? 16'h0000 : didx_r + 16'h0001;
    end
  end

  property p_chan;
    msg_w |-> tx_chan_r == 8'h00;
  endproperty
  a_chan: assert property (p_chan) else $error("offer not on channel zero");
  property p_code;
    msg_w && midx_r == 4'h0 |-> tx_data_r == 8'h20;
  endproperty
  a_code: assert property (p_code) else $error("offer code byte wrong");
  property p_len;
    msg_w && tx_last_r |-> midx_r == 4'hf;
  endproperty
  a_len: assert property (p_len) else $error("offer length not 16");
  property p_tag;
    msg_w && midx_r == 4'h2 |-> tx_data_r == cmd_tag[15:8];
  endproperty
  a_tag: assert property (p_tag) else $error("offer tag high byte wrong");
  property p_align;
    msg_w && (midx_r == 4'h7) |-> tx_data_r[2:0] == 3'h0;
  endproperty
  a_align: assert property (p_align) else $error("offer offset misaligned");
  property p_start;
    cmd_valid && cmd_ready_r && !direct_redirect_mode_bit |-> ##2 msg_w && tx_data_r == 8'h20;
  endproperty
  a_start: assert property (p_start) else $error("no offer after command");
  property p_redir;
    direct_redirect_mode_bit && $past(direct_redirect_mode_bit) |-> !cmd_ready_r;
  endproperty
  a_redir: assert property (p_redir) else $error("ready in redirect mode");
  property p_frame;
    tx_valid_r && !tx_is_msg_r |-> didx_r < FRAME_BYTES
      && (didx_r != FRAME_BYTES - 16'h0001 || tx_last_r);
  endproperty
  a_frame: assert property (p_frame) else $error("data frame too long");
  property p_outst;
    msg_w && tx_last_r && tx_ready |=> offer_outstanding_r;
  endproperty
  a_outst: assert property (p_outst) else $error("sent offer not outstanding");
  property p_err;
    proto_err_r |-> $past(rx_valid && rx_last, 2);
  endproperty
  a_err: assert property (p_err) else $error("error without message end");
endmodule

// File: otf_peer.sv
// Peer node model: takes offers and data, returns queued grants.
`timescale 1ns/1ps
module otf_peer (
  // Clock, reset and pacing.
  input wire clk_sys,
  input wire rst,
  input wire slow,
  // Frames from the engine.
  input wire tx_valid_r,
  input wire [7:0] tx_data_r,
  input wire tx_last_r,
  input wire [7:0] tx_chan_r,
  input wire tx_is_msg_r,
  input wire tx_third_party_r,
  output wire tx_ready,
  // Frames to the engine.
  output logic rx_valid = 1'b0,
  output logic [7:0] rx_data = 8'h00,
  output logic rx_last = 1'b0,
  output logic [7:0] rx_chan = 8'h00
);
  logic [127:0] sh_r, offer;
  logic [7:0] q[$];
  logic [7:0] expd_r, dchan;
  logic [3:0] bidx = 4'h0;
  logic tick_r, tp;
  int offers, dbytes, dbad, frames;

  // Ready every other cycle while slow.
  assign tx_ready = !slow || tick_r;

  // Offers are collected; data must arrive in feed order.
  always @(posedge clk_sys) begin
    if (rst) begin
      tick_r <= 1'b0;
      expd_r <= 8'h00;
      offers <= 0;
      dbytes <= 0;
      dbad <= 0;
      frames <= 0;
    end else begin
      tick_r <= ~tick_r;
      if (tx_valid_r && tx_ready && tx_is_msg_r) begin
        sh_r <= {sh_r[119:0], tx_data_r};
        if (tx_last_r) offer <= {sh_r[119:0], tx_data_r};
        if (tx_last_r) offers <= offers + 1;
      end else if (tx_valid_r && tx_ready) begin
        dbytes <= dbytes + 1;
        if (tx_data_r !== expd_r) dbad <= dbad + 1;
        expd_r <= expd_r + 8'h01;
        dchan <= tx_chan_r;
        tp <= tx_third_party_r;
        if (tx_last_r) frames <= frames + 1;
      end
    end
  end

  // Queues one grant; byte 13 is junk to be ignored.
  task send_grant(input logic [7:0] code, input logic [15:0] tg, input logic [31:0] cnt,
                  input logic [7:0] ch, input logic [15:0] id);
    logic [127:0] m;
    m = {code, 8'h00, tg, 32'h00000000, cnt, ch, ~ch, id};
    for (int i = 15; i >= 0; i--) q.push_back(m[i*8 +: 8]);
  endtask

  // One queued byte a cycle; idle lines keep changing.
  always @(posedge clk_sys) begin
    #1;
    if (q.size() != 0) begin
      rx_valid = 1'b1;
      rx_chan = 8'h00;
      rx_last = (bidx == 4'hf);
      rx_data = q.pop_front();
      bidx = bidx + 4'h1;
    end else begin
      rx_valid = 1'b0;
      rx_last = 1'b0;
      rx_data = ~rx_data;
      rx_chan = ~rx_chan;
    end
  end
endmodule

// File: tb_outbound_transfer_handshake.sv
// Testbench for the outbound transfer engine.
`timescale 1ns/1ps
module tb_outbound_transfer_handshake;
  reg clk_sys = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_abort = 1'b0, wr_valid = 1'b0;
  reg slow = 1'b0, direct_redirect_mode_bit = 1'b0, fed;
  reg [15:0] cmd_tag = 16'h0000;
  reg [31:0] cmd_len = 32'h00000000;
  reg [7:0] wr_data = 8'h00;
  wire wr_ready, rx_valid, rx_last, tx_ready, cmd_ready_r, tx_valid_r, tx_last_r;
  wire tx_is_msg_r, tx_third_party_r, offer_outstanding_r, grant_outstanding_r;
  wire xfer_done_r, proto_err_r;
  wire [7:0] rx_data, rx_chan, tx_data_r, tx_chan_r;
  int fed_cnt = 0, feed_goal = 0, dones = 0, perrs = 0;
  int checked = 0, miscompares = 0;

  always #2.5 clk_sys = ~clk_sys;

  otf_top uut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_tag(cmd_tag),
    .cmd_len(cmd_len), .cmd_ready_r(cmd_ready_r), .cmd_abort(cmd_abort),
    .direct_redirect_mode_bit(direct_redirect_mode_bit), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready(wr_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_chan(rx_chan), .tx_valid_r(tx_valid_r), .tx_ready(tx_ready),
    .tx_data_r(tx_data_r), .tx_last_r(tx_last_r), .tx_chan_r(tx_chan_r),
    .tx_is_msg_r(tx_is_msg_r), .tx_third_party_r(tx_third_party_r),
    .offer_outstanding_r(offer_outstanding_r), .grant_outstanding_r(grant_outstanding_r),
    .xfer_done_r(xfer_done_r), .proto_err_r(proto_err_r));

  otf_peer u_peer (.clk_sys(clk_sys), .rst(rst), .slow(slow), .tx_valid_r(tx_valid_r),
    .tx_data_r(tx_data_r), .tx_last_r(tx_last_r), .tx_chan_r(tx_chan_r),
    .tx_is_msg_r(tx_is_msg_r), .tx_third_party_r(tx_third_party_r), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_chan(rx_chan));

  // Feeder: writes a running byte pattern up to the goal.
  always @(posedge clk_sys) begin
    fed = (wr_valid === 1'b1) && (wr_ready === 1'b1);
    #1;
    if (fed) wr_data = wr_data + 8'h01;
    if (fed) fed_cnt = fed_cnt + 1;
    wr_valid = (fed_cnt != feed_goal);
  end

  // Counts done and error pulses.
  always @(posedge clk_sys) begin
    if (xfer_done_r === 1'b1) dones <= dones + 1;
    if (proto_err_r === 1'b1) perrs <= perrs + 1;
  end

  task chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic wait_cnt(ref int c, input int n);
    for (int k = 0; k < 3000 && c != n; k++) @(posedge clk_sys);
    #1;
    chk(c == n, "count not reached");
  endtask

  task automatic send_cmd(input logic [15:0] tg, input logic [31:0] ln);
    cmd_tag = tg;
    cmd_len = ln;
    cmd_valid = 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (cmd_ready_r === 1'b1) break;
    end
    #1;
    cmd_valid = 1'b0;
  endtask

  task chk_offer(input [15:0] tg, input [31:0] off, input [31:0] cnt, input [15:0] id);
    chk(u_peer.offer === {8'h20, 8'h00, tg, off, cnt, 16'h0000, id}, "offer fields");
  endtask

  // No command is taken while redirect mode is set.
  task t_redirect;
    direct_redirect_mode_bit = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    cmd_valid = 1'b1;
    repeat (20) @(posedge clk_sys);
    #1;
    chk(u_peer.offers == 0 && tx_valid_r === 1'b0, "command taken in redirect mode");
    cmd_valid = 1'b0;
    direct_redirect_mode_bit = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    $display("test redirect done");
  endtask

  // Two offers, back-to-back grants, frame splits, a stalling peer.
  task t_long;
    feed_goal = feed_goal + 264;
    repeat (40) @(posedge clk_sys);
    #1;
    chk(wr_ready === 1'b0 && fed_cnt == 16, "buffer not full");
    send_cmd(16'h5a3c, 32'h00000108);
    wait_cnt(u_peer.offers, 1);
    chk_offer(16'h5a3c, 32'h00000000, 32'h00000100, 16'h0001);
    chk(offer_outstanding_r === 1'b1, "offer not outstanding");
    slow = 1'b1;
    u_peer.send_grant(8'h21, 16'h5a3c, 32'h00000010, 8'h35, 16'h0001);
    u_peer.send_grant(8'h21, 16'h5a3c, 32'h000000f0, 8'h36, 16'h0001);
    wait_cnt(u_peer.dbytes, 256);
    chk(u_peer.frames == 3 && u_peer.dchan === 8'h36, "frames or channel");
    wait_cnt(u_peer.offers, 2);
    chk_offer(16'h5a3c, 32'h00000100, 32'h00000008, 16'h0002);
    u_peer.send_grant(8'h21, 16'h5a3c, 32'h00000008, 8'h37, 16'h0002);
    wait_cnt(u_peer.dbytes, 264);
    wait_cnt(dones, 1);
    chk(u_peer.dbad == 0 && u_peer.frames == 4, "data order");
    chk(offer_outstanding_r === 1'b0 && wr_ready === 1'b1, "offer or buffer left");
    slow = 1'b0;
    $display("test long done");
  endtask

  // Odd final count, rejected grants, then a third-party grant.
  task t_bad;
    feed_goal = feed_goal + 12;
    send_cmd(16'hc0de, 32'h0000000c);
    wait_cnt(u_peer.offers, 3);
    chk_offer(16'hc0de, 32'h00000000, 32'h0000000c, 16'h0003);
    u_peer.send_grant(8'h21, 16'hc0de, 32'h00000004, 8'h40, 16'h0003);
    wait_cnt(perrs, 1);
    u_peer.send_grant(8'h21, 16'hc0de, 32'h0000000c, 8'h40, 16'h0007);
    wait_cnt(perrs, 2);
    u_peer.send_grant(8'h23, 16'hc0de, 32'h0000000c, 8'h41, 16'h0003);
    wait_cnt(u_peer.dbytes, 276);
    wait_cnt(dones, 2);
    chk(u_peer.tp === 1'b1 && u_peer.dchan === 8'h41, "third-party data");
    chk(u_peer.dbad == 0 && u_peer.frames == 5, "data order");
    $display("test bad done");
  endtask

  task stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the expected run.
  initial begin
    #200000;
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test;
  end

  // Main sequence.
  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    t_redirect;
    t_long;
    t_bad;
    stop_test;
  end
endmodule

bind otf_top otf_top_checker #(.FRAME_BYTES(FRAME_BYTES)) u_chk (.clk_sys(clk_sys), .rst(rst),
  .cmd_valid(cmd_valid), .cmd_tag(cmd_tag), .cmd_ready_r(cmd_ready_r),
  .direct_redirect_mode_bit(direct_redirect_mode_bit), .rx_valid(rx_valid),
  .rx_last(rx_last), .tx_valid_r(tx_valid_r), .tx_ready(tx_ready), .tx_data_r(tx_data_r),
  .tx_last_r(tx_last_r), .tx_chan_r(tx_chan_r), .tx_is_msg_r(tx_is_msg_r),
  .offer_outstanding_r(offer_outstanding_r), .proto_err_r(proto_err_r));
